//--- logic/srr_top.sv
// Service request reporting: serial poll codes, request line, event text, line ends.
// Behaviour
// - Serial poll returns pending code, else zero.
// - Timeout, done, breakpoint events use fixed codes.
// - Command errors request service only when enabled.
// - Host stall past lockup time raises event.
// - Power events give no poll code.
// - Pending event drives request line low.
// - New event before poll flags overrun.
// - Listener ends line on LF or EOI.
// - Talker ends line with LF plus EOI.
// - Talk only in reply to queries.
// - No acknowledgement text for silent commands.
// - Listen, talk, serial, parallel poll, request.
// - Address, lockup time, parallel bit configurable.
// - Masked events neither request nor poll.
// - Event text ends CR LF, waits for data.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module srr_top
  import srr_pkg::*;
#(
  parameter int QDEPTH = 8, // Serial character queue depth.
  parameter int LOCK_W = 32 // Lockup counter width.
) (
  input wire logic mclk_in, // 200 MHz clock.
  input wire logic sys_rst_in, // Synchronous reset, high.
  input wire logic [3:0] reg_addr_in, // Register index.
  input wire logic [31:0] reg_wdata_in, // Write data.
  input wire logic reg_wr_in, // Write strobe.
  input wire logic reg_rd_in, // Read strobe.
  output logic [31:0] reg_rdata_out, // Read data, cycle after strobe.
  input wire logic [srr_pkg::NEV-1:0] event_in, // Event pulses, one per source.
  input wire logic spoll_in, // Host serial poll of this device.
  input wire logic ppoll_in, // Host parallel poll.
  output logic [7:0] spoll_byte_out, // Status byte answered to poll.
  output logic ppoll_out, // Parallel poll response bit.
  output logic [7:0] dev_addr_out, // Bus address setting.
  output logic srq_n_out, // Service request, low active.
  input wire logic [7:0] lsn_byte_in, // Listener byte received.
  input wire logic lsn_eoi_in, // End-or-identify with it.
  input wire logic lsn_valid_in, // Byte strobe.
  output logic lsn_line_end_out, // Input line complete pulse.
  input wire logic cmd_done_in, // A parsed command finished.
  input wire logic cmd_err_in, // It was rejected.
  input wire logic cmd_query_in, // It asks for data.
  input wire logic [7:0] talk_byte_in, // Reply byte from parser.
  input wire logic talk_last_in, // Last byte of reply.
  input wire logic talk_valid_in, // Reply byte offered.
  output logic talk_ready_out, // Reply byte taken.
  output logic [7:0] bus_dio_out, // Byte to the talker.
  output logic bus_eoi_out, // EOI with the byte.
  output logic bus_dav_out, // Byte offered to host.
  input wire logic bus_accept_in, // Host accepted the byte (raw pin).
  input wire logic ser_busy_in, // Normal serial data line in progress.
  input wire logic ser_ready_in, // Serial transmitter can take a byte.
  output logic [7:0] ser_byte_out, // Event character to serial.
  output logic ser_valid_out, // Serial byte valid.
  output logic overrun_out, // Request overrun shown to user.
  output logic irq_out // Level interrupt.
);
  srr_if q ();
  srr_char_mem #(.DEPTH(QDEPTH)) u_mem (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .q(q));

  logic [NEV-1:0] stat_reg;
  logic [NEV-1:0] mask_reg;
  logic [31:0] cfg_reg;
  logic [LOCK_W-1:0] lock_reg;
  logic [7:0] pend_code_reg;
  logic [7:0] next_code_reg;
  logic next_valid_reg;
  logic ovr_reg;
  logic [2:0] acc_sync_reg;
  logic acc_reg;
  logic [LOCK_W-1:0] stall_cnt_reg;
  logic talk_armed_reg;
  logic stall_pulse;
  logic [NEV-1:0] ev;
  logic [7:0] new_code;
  logic [7:0] new_char;
  logic poll_take;

  // ==========================================================================
  // Event qualification.
  // Command errors only count as events while reporting is enabled.
  always_comb begin
    ev = event_in;
    ev[EV_STALL] = event_in[EV_STALL] | stall_pulse;
    ev[EV_CERR] = (event_in[EV_CERR] | (cmd_done_in & cmd_err_in)) & cfg_reg[CFG_CERR_EN];
  end
  // Lowest index wins when several sources fire together; masked ones never poll.
  always_comb begin
    new_code = NONE_CODE;
    new_char = 8'h00;
    for (int i = NEV - 1; i >= 0; i--) begin
      if (ev[i] && !mask_reg[i] && poll_code(i) != NONE_CODE) begin
        new_code = poll_code(i);
      end
    end
    for (int i = NEV - 1; i >= 0; i--) begin
      if (ev[i] && !mask_reg[i] && ascii_code(i) != 8'h00) begin
        new_char = ascii_code(i);
      end
    end
  end
  assign poll_take = spoll_in && (pend_code_reg != NONE_CODE);

  // ==========================================================================
  // Serial poll code and overrun.
  // One code is reported, one more waits, later ones are lost; a code arriving while one is pending is an overrun, except in the cycle a poll takes it.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      pend_code_reg <= NONE_CODE;
      next_code_reg <= NONE_CODE;
      next_valid_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      // Clear first, so that an overrun in the same cycle still sets the flag.
      if (reg_wr_in && reg_addr_in == A_POLL) begin
        ovr_reg <= 1'b0;
      end
      if (poll_take) begin
        pend_code_reg <= next_valid_reg ? next_code_reg : NONE_CODE;
        next_valid_reg <= 1'b0;
        if (new_code != NONE_CODE) begin
          if (next_valid_reg) begin
            next_code_reg <= new_code;
            next_valid_reg <= 1'b1;
          end else begin
            pend_code_reg <= new_code;
          end
        end
      end else if (new_code != NONE_CODE) begin
        if (pend_code_reg == NONE_CODE) begin
          pend_code_reg <= new_code;
        end else begin
          ovr_reg <= 1'b1;
          if (!next_valid_reg) begin
            next_code_reg <= new_code;
            next_valid_reg <= 1'b1;
          end
        end
      end
    end
  end
  // Status byte: code when pending, zero otherwise.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      spoll_byte_out <= NONE_CODE;
    end else if (spoll_in) begin
      spoll_byte_out <= pend_code_reg;
    end
  end
  assign srq_n_out = (pend_code_reg == NONE_CODE);
  assign overrun_out = ovr_reg;
  assign dev_addr_out = cfg_reg[CFG_ADDR_LSB +: 8];
  assign ppoll_out = ppoll_in && cfg_reg[CFG_PP_LSB] && !srq_n_out;

  // ==========================================================================
  // Listener line end.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      lsn_line_end_out <= 1'b0;
    end else begin
      lsn_line_end_out <= lsn_valid_in && (lsn_byte_in == LF || lsn_eoi_in);
    end
  end

  // ==========================================================================
  // Talker path with lockup timer.
  // Only a query arms the talker, so no silent command ever produces output.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      talk_armed_reg <= 1'b0;
    end else if (cmd_done_in && cmd_query_in && !cmd_err_in) begin
      talk_armed_reg <= 1'b1;
    end else if (bus_dav_out && acc_reg && bus_eoi_out) begin
      talk_armed_reg <= 1'b0;
    end
  end
  // Full handshake: a stale accept of the last byte must never accept the next.
  assign talk_ready_out = talk_armed_reg && !bus_dav_out && !acc_reg;
  // Accept comes from the host pins; three stages, change when last two agree.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      acc_sync_reg <= 3'b000;
      acc_reg <= 1'b0;
    end else begin
      acc_sync_reg <= {acc_sync_reg[1:0], bus_accept_in};
      if (acc_sync_reg[2] == acc_sync_reg[1]) begin
        acc_reg <= acc_sync_reg[1];
      end
    end
  end
  // The parser supplies reply text; the line ending is always LF with EOI.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      bus_dio_out <= 8'h00;
      bus_eoi_out <= 1'b0;
      bus_dav_out <= 1'b0;
    end else if (talk_valid_in && talk_ready_out) begin
      bus_dio_out <= talk_last_in ? LF : talk_byte_in;
      bus_eoi_out <= talk_last_in;
      bus_dav_out <= 1'b1;
    end else if (acc_reg) begin
      bus_dav_out <= 1'b0;
    end
  end
  // Lockup: the count restarts for every offered byte.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      stall_cnt_reg <= '0;
    end else if (!bus_dav_out || acc_reg) begin
      stall_cnt_reg <= '0;
    end else if (stall_cnt_reg != lock_reg) begin
      stall_cnt_reg <= stall_cnt_reg + 1'b1;
    end
  end
  assign stall_pulse = bus_dav_out && !acc_reg && (stall_cnt_reg == lock_reg - 1'b1);

  // ==========================================================================
  // Serial event text: character, CR, LF; held while a data line runs.
  assign q.wr = (new_char != 8'h00);
  assign q.wdata = new_char;
  srr_tx_e tx_reg;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      tx_reg <= TX_IDLE;
      ser_byte_out <= 8'h00;
      ser_valid_out <= 1'b0;
    end else begin
      case (tx_reg)
        TX_IDLE: begin
          ser_valid_out <= 1'b0;
          if (!q.empty && !ser_busy_in && ser_ready_in) begin
            tx_reg <= TX_CHAR;
          end
        end
        TX_CHAR: begin
          ser_byte_out <= q.rdata;
          ser_valid_out <= 1'b1;
          tx_reg <= TX_CR;
        end
        TX_CR: begin
          ser_valid_out <= ser_ready_in;
          ser_byte_out <= CR;
          if (ser_ready_in) begin
            tx_reg <= TX_LF;
          end
        end
        TX_LF: begin
          ser_valid_out <= ser_ready_in;
          ser_byte_out <= LF;
          if (ser_ready_in) begin
            tx_reg <= TX_IDLE;
          end
        end
        default: tx_reg <= TX_IDLE;
      endcase
    end
  end
  assign q.rd = (tx_reg == TX_IDLE) && !q.empty && !ser_busy_in && ser_ready_in;

  // ==========================================================================
  // Registers; status bits clear on write-one, a new event wins over the clear.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      stat_reg <= '0;
      mask_reg <= '0;
      cfg_reg <= CFG_RST;
      lock_reg <= LOCK_W'(LOCK_RST);
    end else begin
      stat_reg <= (stat_reg & ~((reg_wr_in && reg_addr_in == A_STAT) ?
                  reg_wdata_in[NEV-1:0] : '0)) | ev;
      stat_reg[EV_OVR] <= stat_reg[EV_OVR] & ~(reg_wr_in && reg_addr_in == A_STAT
                          && reg_wdata_in[EV_OVR]) | (new_code != NONE_CODE && !poll_take
                          && pend_code_reg != NONE_CODE);
      if (reg_wr_in && reg_addr_in == A_MASK) begin
        mask_reg <= reg_wdata_in[NEV-1:0];
      end
      if (reg_wr_in && reg_addr_in == A_CFG) begin
        cfg_reg <= reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == A_LOCK) begin
        lock_reg <= reg_wdata_in[LOCK_W-1:0];
      end
    end
  end
  assign irq_out = |(stat_reg & ~mask_reg);
  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_addr_in == A_STAT) begin
      reg_rdata_out <= 32'(stat_reg);
    end else if (reg_addr_in == A_MASK) begin
      reg_rdata_out <= 32'(mask_reg);
    end else if (reg_addr_in == A_CFG) begin
      reg_rdata_out <= cfg_reg;
    end else if (reg_addr_in == A_LOCK) begin
      reg_rdata_out <= 32'(lock_reg);
    end else if (reg_addr_in == A_POLL) begin
      reg_rdata_out <= {23'h000000, ovr_reg, pend_code_reg};
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Checks.
  a_srq_tracks_code: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    new_code != NONE_CODE |=> !srq_n_out) else $error("request line wrong");
  a_poll_answer: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    spoll_in |=> spoll_byte_out == $past(pend_code_reg)) else $error("poll byte wrong");
  a_cerr_gated: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    !cfg_reg[CFG_CERR_EN] |-> !ev[EV_CERR]) else $error("error event leaked");
  a_mask_blocks: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    (ev == (1 << EV_DONE)) && mask_reg[EV_DONE] |-> new_code == NONE_CODE)
    else $error("masked event polled");
  a_overrun_set: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    new_code != NONE_CODE && pend_code_reg != NONE_CODE && !spoll_in |=> overrun_out)
    else $error("overrun missed");
  a_line_end: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    lsn_valid_in && lsn_byte_in == LF |=> lsn_line_end_out) else $error("no line end");
  a_talk_eoi: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    bus_eoi_out |-> bus_dio_out == LF) else $error("EOI without LF");
  a_talk_solicited: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $rose(bus_dav_out) |-> $past(talk_armed_reg)) else $error("unsolicited data");
  sequence s_char_cr;
    tx_reg == TX_CHAR ##1 tx_reg == TX_CR;
  endsequence
  a_crlf_follow: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    tx_reg == TX_CHAR |-> s_char_cr) else $error("CR not after char");
  a_poll_clear: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    poll_take && !next_valid_reg && new_code == NONE_CODE |=> srq_n_out)
    else $error("line not released");
endmodule : srr_top

//--- logic/srr_pkg.sv
// Package of constants, event indices and codes for the service request reporting block.
package srr_pkg;
  // ==========================================================================
  // Event indices.
  localparam int NEV = 18;
  localparam int EV_SP1 = 0;
  localparam int EV_SP2 = 1;
  localparam int EV_CERR = 2;
  localparam int EV_LP1 = 3;
  localparam int EV_LP2 = 4;
  localparam int EV_DONE = 5;
  localparam int EV_DEV1 = 6;
  localparam int EV_DEV2 = 7;
  localparam int EV_UP1 = 8;
  localparam int EV_LO1 = 9;
  localparam int EV_UP2 = 10;
  localparam int EV_LO2 = 11;
  localparam int EV_STALL = 12;
  localparam int EV_PDOWN = 13;
  localparam int EV_PUP = 14;
  localparam int EV_PUPA = 15;
  localparam int EV_BRK = 16;
  localparam int EV_OVR = 17;
  // ==========================================================================
  // Register indices on the plain port.
  localparam logic [3:0] A_STAT = 4'h0;
  localparam logic [3:0] A_MASK = 4'h1;
  localparam logic [3:0] A_CFG = 4'h2;
  localparam logic [3:0] A_LOCK = 4'h3;
  localparam logic [3:0] A_POLL = 4'h4;
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_CERR_EN = 5;
  localparam int CFG_PP_LSB = 8;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] LOCK_RST = 32'h000F_4240;
  // ==========================================================================
  // Bytes.
  localparam logic [7:0] NONE_CODE = 8'h00;
  localparam logic [7:0] LF = 8'h0A;
  localparam logic [7:0] CR = 8'h0D;
  localparam logic [7:0] RQS_BIT = 8'h40;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_CHAR = 4'b0010,
    TX_CR = 4'b0100,
    TX_LF = 4'b1000
  } srr_tx_e;
  // Serial-poll code of an event, zero for events that never poll.
  function automatic logic [7:0] poll_code(input int idx);
    case (idx)
      EV_SP1: poll_code = 8'h41;
      EV_SP2: poll_code = 8'h51;
      EV_CERR: poll_code = 8'h42;
      EV_LP1: poll_code = 8'h43;
      EV_LP2: poll_code = 8'h53;
      EV_DONE: poll_code = 8'h45;
      EV_DEV1: poll_code = 8'h46;
      EV_DEV2: poll_code = 8'h56;
      EV_UP1: poll_code = 8'h47;
      EV_LO1: poll_code = 8'h4A;
      EV_UP2: poll_code = 8'h57;
      EV_LO2: poll_code = 8'h5A;
      EV_STALL: poll_code = 8'h4F;
      EV_BRK: poll_code = 8'h50;
      default: poll_code = 8'h00;
    endcase
  endfunction : poll_code
  // Serial-port character of an event, zero when none.
  function automatic logic [7:0] ascii_code(input int idx);
    case (idx)
      EV_SP1: ascii_code = 8'h49;
      EV_SP2: ascii_code = 8'h4A;
      EV_CERR: ascii_code = 8'h21;
      EV_LP1: ascii_code = 8'h50;
      EV_LP2: ascii_code = 8'h51;
      EV_DONE: ascii_code = 8'h45;
      EV_DEV1: ascii_code = 8'h44;
      EV_DEV2: ascii_code = 8'h46;
      EV_UP1: ascii_code = 8'h4F;
      EV_LO1: ascii_code = 8'h55;
      EV_UP2: ascii_code = 8'h2B;
      EV_LO2: ascii_code = 8'h2D;
      EV_PDOWN: ascii_code = 8'h21;
      EV_PUP: ascii_code = 8'h5A;
      EV_PUPA: ascii_code = 8'h5A;
      EV_BRK: ascii_code = 8'h42;
      default: ascii_code = 8'h00;
    endcase
  endfunction : ascii_code
endpackage : srr_pkg

//--- logic/srr_if.sv
// Interface carrying serial event characters to the character queue.
`timescale 1ns/10ps
interface srr_if;
  logic wr;
  logic [7:0] wdata;
  logic full;
  logic rd;
  logic [7:0] rdata;
  logic empty;
  modport src (output wr, output wdata, input full, output rd, input rdata, input empty);
  modport mem (input wr, input wdata, output full, input rd, output rdata, output empty);
endinterface : srr_if

//--- logic/srr_char_mem.sv
// Small memory queuing serial event characters, registered read data.
`timescale 1ns/10ps
module srr_char_mem #(
  parameter int DEPTH = 8 // Entries, power of two.
) (
  input wire logic mclk_in, // System clock.
  input wire logic sys_rst_in, // Synchronous reset.
  srr_if.mem q // Queue port.
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] mem_reg [DEPTH];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;
  logic [7:0] rdata_reg;
  // Pointers carry one extra bit so full and empty differ.
  assign q.empty = (wp_reg == rp_reg);
  assign q.full = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  assign q.rdata = rdata_reg;
  // Write side.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wp_reg <= '0;
    end else if (q.wr && !q.full) begin
      mem_reg[wp_reg[AW-1:0]] <= q.wdata;
      wp_reg <= wp_reg + 1'b1;
    end
  end
  // Read side; the head is registered the cycle it is popped.
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rp_reg <= '0;
      rdata_reg <= 8'h00;
    end else if (q.rd && !q.empty) begin
      rdata_reg <= mem_reg[rp_reg[AW-1:0]];
      rp_reg <= rp_reg + 1'b1;
    end
  end
endmodule : srr_char_mem

//--- dv/srr_host_model.sv
// Host bus controller model: serial poll strobe and byte acceptance.
`timescale 1ns/10ps
module srr_host_model (
  input wire logic mclk_in, // System clock.
  input wire logic stall_in, // Hold off acceptance.
  input wire logic dav_in, // Byte offered by the device.
  input wire logic [7:0] poll_byte_in, // Status byte answer.
  output logic accept_out = 1'b0, // Byte accepted pin.
  output logic poll_out = 1'b0 // Serial poll strobe.
);
  logic [1:0] dly_reg = 2'h0;
  // ==========================================================================
  // Accept an offered byte a few cycles late, as a slow host would.
  // Acceptance drops once the byte is withdrawn, so every byte is a full cycle.
  always @(posedge mclk_in) begin
    if (!dav_in || stall_in) begin
      dly_reg <= 2'h0;
    end else if (dly_reg != 2'h3) begin
      dly_reg <= dly_reg + 2'h1;
    end
    accept_out <= dav_in && !stall_in && dly_reg == 2'h3;
  end
  // One-cycle poll strobe; the answer is taken in the cycle after it.
  task automatic poll(output logic [7:0] b);
    @(posedge mclk_in);
    poll_out <= 1'b1;
    @(posedge mclk_in);
    poll_out <= 1'b0;
    #1 b = poll_byte_in;
  endtask : poll
endmodule : srr_host_model

//--- dv/srr_top_tb.sv
// Self-checking bench of the service request reporting block.
`timescale 1ns/10ps
module srr_top_tb;
  import srr_pkg::*;
  logic mclk_in, sys_rst_in, reg_wr_in, reg_rd_in, ppoll_in, lsn_eoi_in, lsn_valid_in;
  logic cmd_done_in, cmd_err_in, cmd_query_in, talk_last_in, talk_valid_in, stall;
  logic ser_busy_in, ser_ready_in, spoll_in, bus_accept_in, ppoll_out, srq_n_out;
  logic lsn_line_end_out, talk_ready_out, bus_eoi_out, bus_dav_out, ser_valid_out;
  logic overrun_out, irq_out, dav_q;
  logic [3:0] reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic [NEV-1:0] event_in;
  logic [7:0] spoll_byte_out, dev_addr_out, lsn_byte_in, talk_byte_in, bus_dio_out, ser_byte_out;
  logic [8:0] busq[$];
  logic [7:0] serq[$];
  int mismatches = 0;
  int checks_done = 0;
  localparam logic [7:0] CODES [17] = '{8'h41, 8'h51, 8'h42, 8'h43, 8'h53, 8'h45, 8'h46,
    8'h56, 8'h47, 8'h4A, 8'h57, 8'h5A, 8'h4F, 8'h00, 8'h00, 8'h00, 8'h50};
  srr_top u_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .event_in(event_in), .spoll_in(spoll_in),
    .ppoll_in(ppoll_in), .spoll_byte_out(spoll_byte_out), .ppoll_out(ppoll_out),
    .dev_addr_out(dev_addr_out), .srq_n_out(srq_n_out), .lsn_byte_in(lsn_byte_in),
    .lsn_eoi_in(lsn_eoi_in), .lsn_valid_in(lsn_valid_in), .lsn_line_end_out(lsn_line_end_out),
    .cmd_done_in(cmd_done_in), .cmd_err_in(cmd_err_in), .cmd_query_in(cmd_query_in),
    .talk_byte_in(talk_byte_in), .talk_last_in(talk_last_in), .talk_valid_in(talk_valid_in),
    .talk_ready_out(talk_ready_out), .bus_dio_out(bus_dio_out), .bus_eoi_out(bus_eoi_out),
    .bus_dav_out(bus_dav_out), .bus_accept_in(bus_accept_in), .ser_busy_in(ser_busy_in),
    .ser_ready_in(ser_ready_in), .ser_byte_out(ser_byte_out), .ser_valid_out(ser_valid_out),
    .overrun_out(overrun_out), .irq_out(irq_out));
  srr_host_model u_host (.mclk_in(mclk_in), .stall_in(stall), .dav_in(bus_dav_out),
    .poll_byte_in(spoll_byte_out), .accept_out(bus_accept_in), .poll_out(spoll_in));
  // ==========================================================================
  // Expected poll code of an event index.
  function automatic logic [7:0] exp_code(int i);
    return CODES[i];
  endfunction : exp_code
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // ==========================================================================
  // Bus and stimulus tasks; every strobe is one cycle, driven just after an edge.
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge mclk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask : wr
  task automatic rd(logic [3:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask : rd
  task automatic pulse(int i);
    @(posedge mclk_in);
    event_in <= NEV'(1) << i;
    @(posedge mclk_in);
    event_in <= '0;
    @(posedge mclk_in);
    #1;
  endtask : pulse
  task automatic cmd_issue(logic e, logic q);
    @(posedge mclk_in);
    cmd_done_in <= 1'b1;
    cmd_err_in <= e;
    cmd_query_in <= q;
    @(posedge mclk_in);
    cmd_done_in <= 1'b0;
    @(posedge mclk_in);
    #1;
  endtask : cmd_issue
  task automatic lsn(logic [7:0] b, logic e, logic exp);
    @(posedge mclk_in);
    lsn_valid_in <= 1'b1;
    lsn_byte_in <= b;
    lsn_eoi_in <= e;
    @(posedge mclk_in);
    lsn_valid_in <= 1'b0;
    #1 chk("line_end", lsn_line_end_out, exp);
  endtask : lsn
  // Offer one reply byte and hold it until the block takes it.
  task automatic talk(logic [7:0] b, logic l);
    int n;
    @(posedge mclk_in);
    talk_valid_in <= 1'b1;
    talk_byte_in <= b;
    talk_last_in <= l;
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (talk_ready_out !== 1'b1 && n < 300);
    @(posedge mclk_in);
    talk_valid_in <= 1'b0;
  endtask : talk
  task automatic poll_chk(logic [7:0] e);
    logic [7:0] b;
    u_host.poll(b);
    chk("poll", b, e);
  endtask : poll_chk
  // ==========================================================================
  // Clock and a watchdog that ends a hung run as a failure.
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  // Record bytes offered on the bus and characters sent on the serial port.
  always @(posedge mclk_in) begin
    dav_q <= bus_dav_out;
    if (bus_dav_out && !dav_q) busq.push_back({bus_eoi_out, bus_dio_out});
    if (ser_valid_out && ser_ready_in) serq.push_back(ser_byte_out);
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    logic [31:0] d;
    int idx;
    {reg_wr_in, reg_rd_in, ppoll_in, lsn_eoi_in, lsn_valid_in, cmd_done_in} = '0;
    {cmd_err_in, cmd_query_in, talk_last_in, talk_valid_in, stall, ser_busy_in, dav_q} = '0;
    {reg_addr_in, reg_wdata_in, event_in, lsn_byte_in, talk_byte_in} = '0;
    sys_rst_in = 1'b1;
    ser_ready_in = 1'b1;
    void'($urandom(32'hB584));
    repeat (2) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    #1 chk("srq_rst", srq_n_out, 1'b1);
    rd(A_CFG, d);
    chk("cfg_rst", d, CFG_RST);
    rd(A_LOCK, d);
    chk("lock_rst", d, LOCK_RST);
    rd(4'hF, d);
    chk("unmapped", d, 32'h0);
    wr(A_MASK, 32'h0);
    wr(A_CFG, 32'h0000_0107);
    ppoll_in <= 1'b1;
    #1 chk("addr", dev_addr_out, 8'h07);
    // Event sources 0 to 16 in turn, except command error and stall, then a random mix of them.
    for (int k = 0; k < 40; k++) begin
      idx = (k < 17) ? k : $urandom_range(16, 0);
      if (idx == EV_CERR || idx == EV_STALL) continue;
      pulse(idx);
      chk("srq", srq_n_out, exp_code(idx) == 8'h00);
      chk("ppoll", ppoll_out, exp_code(idx) != 8'h00);
      poll_chk(exp_code(idx));
      @(posedge mclk_in);
      #1 chk("srq_rel", srq_n_out, 1'b1);
    end
    // Command errors request service only while reporting is on.
    cmd_issue(1'b1, 1'b0);
    chk("cerr_off", srq_n_out, 1'b1);
    poll_chk(NONE_CODE);
    wr(A_CFG, 32'h0000_0127);
    cmd_issue(1'b1, 1'b0);
    chk("cerr_on", srq_n_out, 1'b0);
    poll_chk(8'h42);
    // A second and third event before the host polls.
    pulse(EV_SP1);
    pulse(EV_LP1);
    chk("ovr", overrun_out, 1'b1);
    pulse(EV_DONE);
    poll_chk(8'h41);
    poll_chk(8'h43);
    poll_chk(NONE_CODE);
    wr(A_POLL, 32'h0);
    #1 chk("ovr_clr", overrun_out, 1'b0);
    // Masking, sticky status and the interrupt output.
    wr(A_STAT, 32'h0003_FFFF);
    wr(A_MASK, 32'h1 << EV_DONE);
    pulse(EV_DONE);
    chk("mask_srq", srq_n_out, 1'b1);
    chk("mask_irq", irq_out, 1'b0);
    poll_chk(NONE_CODE);
    wr(A_MASK, 32'h0);
    #1 chk("irq", irq_out, 1'b1);
    poll_chk(NONE_CODE);
    wr(A_STAT, 32'h1 << EV_DONE);
    #1 chk("irq_clr", irq_out, 1'b0);
    rd(A_STAT, d);
    chk("stat_clr", d[EV_DONE], 1'b0);
    // Listener line ends.
    lsn(8'($urandom_range(8'h7E, 8'h20)), 1'b0, 1'b0);
    lsn(LF, 1'b0, 1'b1);
    lsn(8'h42, 1'b1, 1'b1);
    lsn(LF, 1'b1, 1'b1);
    // No reply without a query, then a query reply ending in LF with EOI.
    cmd_issue(1'b0, 1'b0);
    @(posedge mclk_in);
    talk_valid_in <= 1'b1;
    repeat (10) @(posedge mclk_in);
    talk_valid_in <= 1'b0;
    #1 chk("unsolicited", {talk_ready_out, bus_dav_out}, 2'b00);
    cmd_issue(1'b0, 1'b1);
    talk(8'h41, 1'b0);
    talk(8'h42, 1'b1);
    for (int i = 0; i < 300 && busq.size() < 2; i++) @(posedge mclk_in);
    chk("talk0", busq[0], 9'h041);
    chk("talk1", busq[1], {1'b1, LF});
    // Host stalls past the lockup time.
    repeat (20) @(posedge mclk_in);
    wr(A_LOCK, 32'd20);
    rd(A_LOCK, d);
    chk("lock", d, 32'd20);
    stall <= 1'b1;
    cmd_issue(1'b0, 1'b1);
    talk(8'h58, 1'b1);
    repeat (40) @(posedge mclk_in);
    #1 chk("stall_srq", srq_n_out, 1'b0);
    poll_chk(8'h4F);
    stall <= 1'b0;
    // Event text is withheld during a data line, then ends CR LF.
    repeat (40) @(posedge mclk_in);
    serq.delete();
    ser_busy_in <= 1'b1;
    pulse(EV_DONE);
    repeat (20) @(posedge mclk_in);
    #1 chk("ser_hold", serq.size(), 0);
    ser_busy_in <= 1'b0;
    repeat (20) @(posedge mclk_in);
    #1 chk("ser_n", serq.size(), 3);
    chk("ser_ch", serq[0], 8'h45);
    chk("ser_cr", serq[1], CR);
    chk("ser_lf", serq[2], LF);
    final_report();
  end
endmodule : srr_top_tb
